// File: core/pcb_regs.vh
// Register map constants for the synthesizer configuration bank
`ifndef PCB_REGS_VH
`define PCB_REGS_VH
`define PCB_ADDR_STROBE  6'h00
`define PCB_ADDR_ENABLE  6'h01
`define PCB_ADDR_FORCE   6'h02
`define PCB_ADDR_REFPATH 6'h03
`define PCB_ADDR_DUTY    6'h04
`define PCB_ADDR_PDCTL   6'h05
`define PCB_ADDR_PDDLY   6'h06
`define PCB_ADDR_GAIN    6'h07
`define PCB_ADDR_TRIM    6'h08
`define PCB_RST_ENABLE   16'hFE9B
`define PCB_RST_FORCE    2'h3
`define PCB_RST_REFPATH  17'h0_8001
`define PCB_RST_DUTY     1'h0
`define PCB_RST_PDCTL    3'h6
`define PCB_RST_PDDLY    3'h2
`define PCB_RST_GAIN     10'h210
`define PCB_RST_TRIM     18'h2_0400
`define PCB_STB_SWRST    0
`define PCB_EN_BIAS      1
`define PCB_EN_REFDIV    2
`define PCB_EN_XMUX      3
`define PCB_EN_DIVDIG    4
`define PCB_EN_SQDIG     5
`define PCB_EN_SINDIG    6
`define PCB_EN_SQBUF     7
`define PCB_EN_SINBUF    8
`define PCB_EN_VCOCLK    9
`define PCB_EN_LKDPFD    11
`define PCB_EN_PUMP      12
`define PCB_EN_MODRUN    13
`define PCB_EN_LKDRUN    14
`define PCB_EN_CSGUARD   15
`define PCB_RP_SEL       14
`define PCB_RP_AUTO      15
`define PCB_RP_SIN       16
`endif

// File: core/pcb_bank.v
// Configuration register bank of the fractional-N synthesizer
// How it works
// - Bias bit zero disables loop except clock and divider selects
// - Divider enable clear holds divider reset
// - Bit 9 picks modulator clock source
// - Bit 11 enables and resets lock detector
// - Pump enable clear tri-states pump output
// - Bit 13 low holds modulator reset
// - Bit 14 releases lock detect circuit
// - Bit 15 releases cycle slip flops
// - Buffers gated by sine select bit
// - Bits 3-6 gate reference clocks
// - Force enable drives held pin value
// - Ratio divides crystal; zero forbidden
// - Divider select, auto bypass ratio one
// - Duty bit lengthens prescaler low time
// - Bit 0 inverts detector polarity
// - Bits 1,2 mask up/down pulses
// - Two 5-bit pump gain codes
// - Two 4-bit trim codes
// - Two 4-bit leakage codes
// - Writes carry address then 24 data
// - Soft reset strobe restores defaults
`timescale 1ns/100ps
`default_nettype none
`include "pcb_regs.vh"
module pcb_bank (
  input  wire        clk,
  input  wire        rst,
  input  wire        wr_stb,
  input  wire [5:0]  wr_addr,
  input  wire [23:0] wr_data,
  input  wire [5:0]  rd_addr,
  output reg  [23:0] rd_data,
  output reg         loop_enable,
  output reg         vco_buf_enable,
  output reg         ref_div_run,
  output reg         ref_div_use,
  output reg  [13:0] ref_div_ratio,
  output reg         xmux_clk_gate,
  output reg         div_clk_gate,
  output reg         sq_clk_gate,
  output reg         sin_clk_gate,
  output reg         square_ref_buffer_enable,
  output reg         sine_ref_buffer_enable,
  output reg         mod_clk_from_vco,
  output reg         presc_bias_enable,
  output reg         lock_det_run,
  output reg         pump_output_enable,
  output reg         mod_run,
  output reg         lock_circ_run,
  output reg         cycle_slip_guard,
  output reg         lock_or_readback_pin_o,
  output reg         lock_or_readback_pin_oe,
  output reg         presc_long_low,
  output reg         pd_invert,
  output reg         pd_up_pass,
  output reg         pd_down_pass,
  output reg  [2:0]  pd_delay,
  output reg  [4:0]  pump_up_gain_code,
  output reg  [4:0]  pump_down_gain_code,
  output reg  [3:0]  pump_up_trim_code,
  output reg  [3:0]  pump_down_trim_code,
  output reg  [3:0]  pump_up_leak_code,
  output reg  [3:0]  pump_down_leak_code,
  output reg  [1:0]  pump_dummy_bias_code
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  reg [15:0] enable_and_reset_control;
  reg [1:0]  readback_pin_force;
  reg [16:0] reference_path_control;
  reg [0:0]  prescaler_duty_control;
  reg [2:0]  phase_detector_control;
  reg [2:0]  phase_detector_delay;
  reg [9:0]  pump_current_gain;
  reg [17:0] pump_trim_offset;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire soft_reset;
  assign soft_reset = wr_stb && (wr_addr == `PCB_ADDR_STROBE) &&
                      wr_data[`PCB_STB_SWRST];

  always @(posedge clk) begin
    if (rst || soft_reset) begin
      enable_and_reset_control <= `PCB_RST_ENABLE;
      readback_pin_force       <= `PCB_RST_FORCE;
      reference_path_control   <= `PCB_RST_REFPATH;
      prescaler_duty_control   <= `PCB_RST_DUTY;
      phase_detector_control   <= `PCB_RST_PDCTL;
      phase_detector_delay     <= `PCB_RST_PDDLY;
      pump_current_gain        <= `PCB_RST_GAIN;
      pump_trim_offset         <= `PCB_RST_TRIM;
    end else if (wr_stb) begin
      if (wr_addr == `PCB_ADDR_ENABLE) begin
        enable_and_reset_control <= wr_data[15:0];
      end else if (wr_addr == `PCB_ADDR_FORCE) begin
        readback_pin_force <= wr_data[1:0];
      end else if (wr_addr == `PCB_ADDR_REFPATH) begin
        reference_path_control <= wr_data[16:0];
      end else if (wr_addr == `PCB_ADDR_DUTY) begin
        prescaler_duty_control <= wr_data[0:0];
      end else if (wr_addr == `PCB_ADDR_PDCTL) begin
        phase_detector_control <= wr_data[2:0];
      end else if (wr_addr == `PCB_ADDR_PDDLY) begin
        phase_detector_delay <= wr_data[2:0];
      end else if (wr_addr == `PCB_ADDR_GAIN) begin
        pump_current_gain <= wr_data[9:0];
      end else if (wr_addr == `PCB_ADDR_TRIM) begin
        pump_trim_offset <= wr_data[17:0];
      end
    end
  end

  // ----------------------------------------
  // Readback
  // ----------------------------------------
  reg [23:0] next_rd_data;
  always @* begin
    next_rd_data = 24'h00_0000;
    if (rd_addr == `PCB_ADDR_ENABLE) begin
      next_rd_data = {8'h00, enable_and_reset_control};
    end else if (rd_addr == `PCB_ADDR_FORCE) begin
      next_rd_data = {22'h00_0000, readback_pin_force};
    end else if (rd_addr == `PCB_ADDR_REFPATH) begin
      next_rd_data = {7'h00, reference_path_control};
    end else if (rd_addr == `PCB_ADDR_DUTY) begin
      next_rd_data = {23'h00_0000, prescaler_duty_control};
    end else if (rd_addr == `PCB_ADDR_PDCTL) begin
      next_rd_data = {21'h00_0000, phase_detector_control};
    end else if (rd_addr == `PCB_ADDR_PDDLY) begin
      next_rd_data = {21'h00_0000, phase_detector_delay};
    end else if (rd_addr == `PCB_ADDR_GAIN) begin
      next_rd_data = {14'h0000, pump_current_gain};
    end else if (rd_addr == `PCB_ADDR_TRIM) begin
      next_rd_data = {6'h00, pump_trim_offset};
    end
  end

  // ----------------------------------------
  // Derived controls
  // ----------------------------------------
  wire [15:0] en;
  wire        bias;
  wire        sin_sel;
  wire        ratio_one;
  assign en        = enable_and_reset_control;
  assign bias      = en[`PCB_EN_BIAS];
  assign sin_sel   = reference_path_control[`PCB_RP_SIN];
  assign ratio_one = (reference_path_control[13:0] == 14'h0001);

  // ----------------------------------------
  // Next output values
  // ----------------------------------------
  reg        next_loop_enable;
  reg        next_vco_buf_enable;
  reg        next_ref_div_run;
  reg        next_ref_div_use;
  reg [13:0] next_ref_div_ratio;
  reg        next_xmux_clk_gate;
  reg        next_div_clk_gate;
  reg        next_sq_clk_gate;
  reg        next_sin_clk_gate;
  reg        next_square_ref_buffer_enable;
  reg        next_sine_ref_buffer_enable;
  reg        next_mod_clk_from_vco;
  reg        next_presc_bias_enable;
  reg        next_lock_det_run;
  reg        next_pump_output_enable;
  reg        next_mod_run;
  reg        next_lock_circ_run;
  reg        next_cycle_slip_guard;
  reg        next_lock_or_readback_pin_o;
  reg        next_lock_or_readback_pin_oe;
  reg        next_presc_long_low;
  reg        next_pd_invert;
  reg        next_pd_up_pass;
  reg        next_pd_down_pass;
  reg [2:0]  next_pd_delay;
  reg [4:0]  next_pump_up_gain_code;
  reg [4:0]  next_pump_down_gain_code;
  reg [3:0]  next_pump_up_trim_code;
  reg [3:0]  next_pump_down_trim_code;
  reg [3:0]  next_pump_up_leak_code;
  reg [3:0]  next_pump_down_leak_code;
  reg [1:0]  next_pump_dummy_bias_code;

  always @* begin
    next_loop_enable       = bias;
    next_vco_buf_enable    = bias & en[0];
    next_presc_bias_enable = bias & en[10];
    next_ref_div_run = bias & en[`PCB_EN_REFDIV];
    next_ref_div_use = en[`PCB_EN_REFDIV] &
                       (reference_path_control[`PCB_RP_AUTO] ? ~ratio_one :
                        reference_path_control[`PCB_RP_SEL]);
    next_ref_div_ratio = reference_path_control[13:0];

    next_xmux_clk_gate = bias & en[`PCB_EN_XMUX];
    next_div_clk_gate  = bias & en[`PCB_EN_DIVDIG];
    next_sq_clk_gate   = bias & en[`PCB_EN_SQDIG];
    next_sin_clk_gate  = bias & en[`PCB_EN_SINDIG];
    next_square_ref_buffer_enable = bias & en[`PCB_EN_SQBUF] & ~sin_sel;
    next_sine_ref_buffer_enable   = bias & en[`PCB_EN_SINBUF] & sin_sel;

    next_mod_clk_from_vco = en[`PCB_EN_VCOCLK];
    next_lock_det_run = bias & en[`PCB_EN_LKDPFD];
    next_pump_output_enable = bias & en[`PCB_EN_PUMP];
    next_mod_run = bias & en[`PCB_EN_MODRUN];
    next_lock_circ_run = bias & en[`PCB_EN_LKDRUN];
    next_cycle_slip_guard = bias & en[`PCB_EN_CSGUARD];

    next_lock_or_readback_pin_o  = readback_pin_force[0];
    next_lock_or_readback_pin_oe = readback_pin_force[1];
    next_presc_long_low = prescaler_duty_control[0];
    next_pd_invert    = phase_detector_control[0];
    next_pd_up_pass   = phase_detector_control[1];
    next_pd_down_pass = phase_detector_control[2];
    next_pd_delay     = phase_detector_delay;

    next_pump_up_gain_code   = pump_current_gain[4:0];
    next_pump_down_gain_code = pump_current_gain[9:5];
    next_pump_up_trim_code   = pump_trim_offset[3:0];
    next_pump_down_trim_code = pump_trim_offset[7:4];
    next_pump_up_leak_code   = pump_trim_offset[11:8];
    next_pump_down_leak_code = pump_trim_offset[15:12];
    next_pump_dummy_bias_code = pump_trim_offset[17:16];
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      rd_data                  <= 24'h00_0000;
      loop_enable              <= 1'b0;
      vco_buf_enable           <= 1'b0;
      ref_div_run              <= 1'b0;
      ref_div_use              <= 1'b0;
      ref_div_ratio            <= 14'h0001;
      xmux_clk_gate            <= 1'b0;
      div_clk_gate             <= 1'b0;
      sq_clk_gate              <= 1'b0;
      sin_clk_gate             <= 1'b0;
      square_ref_buffer_enable <= 1'b0;
      sine_ref_buffer_enable   <= 1'b0;
      mod_clk_from_vco         <= 1'b0;
      presc_bias_enable        <= 1'b0;
      lock_det_run             <= 1'b0;
      pump_output_enable       <= 1'b0;
      mod_run                  <= 1'b0;
      lock_circ_run            <= 1'b0;
      cycle_slip_guard         <= 1'b0;
      lock_or_readback_pin_o   <= 1'b0;
      lock_or_readback_pin_oe  <= 1'b0;
      presc_long_low           <= 1'b0;
      pd_invert                <= 1'b0;
      pd_up_pass               <= 1'b0;
      pd_down_pass             <= 1'b0;
      pd_delay                 <= 3'h0;
      pump_up_gain_code        <= 5'h00;
      pump_down_gain_code      <= 5'h00;
      pump_up_trim_code        <= 4'h0;
      pump_down_trim_code      <= 4'h0;
      pump_up_leak_code        <= 4'h0;
      pump_down_leak_code      <= 4'h0;
      pump_dummy_bias_code     <= 2'h0;
    end else begin
      rd_data                  <= next_rd_data;
      loop_enable              <= next_loop_enable;
      vco_buf_enable           <= next_vco_buf_enable;
      ref_div_run              <= next_ref_div_run;
      ref_div_use              <= next_ref_div_use;
      ref_div_ratio            <= next_ref_div_ratio;
      xmux_clk_gate            <= next_xmux_clk_gate;
      div_clk_gate             <= next_div_clk_gate;
      sq_clk_gate              <= next_sq_clk_gate;
      sin_clk_gate             <= next_sin_clk_gate;
      square_ref_buffer_enable <= next_square_ref_buffer_enable;
      sine_ref_buffer_enable   <= next_sine_ref_buffer_enable;
      mod_clk_from_vco         <= next_mod_clk_from_vco;
      presc_bias_enable        <= next_presc_bias_enable;
      lock_det_run             <= next_lock_det_run;
      pump_output_enable       <= next_pump_output_enable;
      mod_run                  <= next_mod_run;
      lock_circ_run            <= next_lock_circ_run;
      cycle_slip_guard         <= next_cycle_slip_guard;
      lock_or_readback_pin_o   <= next_lock_or_readback_pin_o;
      lock_or_readback_pin_oe  <= next_lock_or_readback_pin_oe;
      presc_long_low           <= next_presc_long_low;
      pd_invert                <= next_pd_invert;
      pd_up_pass               <= next_pd_up_pass;
      pd_down_pass             <= next_pd_down_pass;
      pd_delay                 <= next_pd_delay;
      pump_up_gain_code        <= next_pump_up_gain_code;
      pump_down_gain_code      <= next_pump_down_gain_code;
      pump_up_trim_code        <= next_pump_up_trim_code;
      pump_down_trim_code      <= next_pump_down_trim_code;
      pump_up_leak_code        <= next_pump_up_leak_code;
      pump_down_leak_code      <= next_pump_down_leak_code;
      pump_dummy_bias_code     <= next_pump_dummy_bias_code;
    end
  end

endmodule
`default_nettype wire

// File: bench/pcb_host.sv
// Host model issuing deserialised register writes
`timescale 1ns/100ps
`default_nettype none
module pcb_host (
  input  wire logic        clk,
  output var  logic        wr_stb,
  output var  logic [5:0]  wr_addr,
  output var  logic [23:0] wr_data
);
  initial begin
    wr_stb = 1'b0;
    wr_addr = 6'h00;
    wr_data = 24'h00_0000;
  end
  task automatic write(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    wr_addr <= ~a;
    wr_data <= ~d;
  endtask
endmodule
`default_nettype wire

// File: bench/pcb_assertions.sv
// Port-level checks of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module pcb_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wr_stb,
  input wire logic [5:0]  wr_addr,
  input wire logic [23:0] wr_data,
  input wire logic [5:0]  rd_addr,
  input wire logic [23:0] rd_data,
  input wire logic        loop_enable,
  input wire logic        ref_div_run,
  input wire logic        pump_output_enable,
  input wire logic        mod_run,
  input wire logic        square_ref_buffer_enable,
  input wire logic        sine_ref_buffer_enable,
  input wire logic        lock_or_readback_pin_o,
  input wire logic        lock_or_readback_pin_oe,
  input wire logic        pd_invert,
  input wire logic        pd_up_pass,
  input wire logic        pd_down_pass,
  input wire logic [2:0]  pd_delay,
  input wire logic [4:0]  pump_up_gain_code,
  input wire logic [4:0]  pump_down_gain_code,
  input wire logic [3:0]  pump_up_trim_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_bias_gates_loop: assert property (
    !loop_enable |-> !(ref_div_run | pump_output_enable | mod_run
      | square_ref_buffer_enable | sine_ref_buffer_enable))
    else $error("enable active with bias off");
  a_one_ref_buffer: assert property (
    !(square_ref_buffer_enable && sine_ref_buffer_enable))
    else $error("both reference buffers on");
  a_force_pin_drive: assert property (
    wr_stb && wr_addr == 6'h02 |-> ##2
      lock_or_readback_pin_oe == $past(wr_data[1], 2)
      && lock_or_readback_pin_o == $past(wr_data[0], 2))
    else $error("pin force mismatch");
  a_pd_polarity_mask: assert property (
    wr_stb && wr_addr == 6'h05 |-> ##2
      {pd_down_pass, pd_up_pass, pd_invert} == $past(wr_data[2:0], 2))
    else $error("detector control mismatch");
  a_pump_gain_codes: assert property (
    wr_stb && wr_addr == 6'h07 |-> ##2
      {pump_down_gain_code, pump_up_gain_code} == $past(wr_data[9:0], 2))
    else $error("pump gain mismatch");
  a_pump_trim_code: assert property (
    wr_stb && wr_addr == 6'h08 |-> ##2
      pump_up_trim_code == $past(wr_data[3:0], 2))
    else $error("pump trim mismatch");
  a_soft_reset_defaults: assert property (
    wr_stb && wr_addr == 6'h00 && wr_data[0] |-> ##2
      pd_delay == 3'h2 && pump_up_gain_code == 5'h10
      && lock_or_readback_pin_oe && !pd_invert)
    else $error("soft reset defaults wrong");
  a_delay_readback: assert property (
    wr_stb && wr_addr == 6'h06 && rd_addr == 6'h06 ##1 rd_addr == 6'h06
      |-> ##1 rd_data == {21'h00_0000, $past(wr_data[2:0], 2)})
    else $error("delay readback wrong");
endmodule
bind pcb_bank pcb_assertions pcb_assertions_i (.clk, .rst, .wr_stb,
  .wr_addr, .wr_data, .rd_addr, .rd_data, .loop_enable, .ref_div_run,
  .pump_output_enable, .mod_run, .square_ref_buffer_enable,
  .sine_ref_buffer_enable, .lock_or_readback_pin_o, .lock_or_readback_pin_oe,
  .pd_invert, .pd_up_pass, .pd_down_pass, .pd_delay, .pump_up_gain_code,
  .pump_down_gain_code, .pump_up_trim_code);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench of the configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk, rst, wr_stb, loop_enable, ref_div_use, mod_run;
  logic        mod_clk_from_vco, pump_output_enable, sq_buf, sin_buf;
  logic        pin_o, pin_oe;
  logic [5:0]  wr_addr, rd_addr, a;
  logic [23:0] wr_data, rd_data, d;
  logic [13:0] ref_div_ratio;
  logic [15:0] en_s;
  logic [16:0] rp_s;
  logic [1:0]  fr_s;
  logic [23:0] sh [9];
  wire  [9:0]  en_o;
  wire  [16:0] pd_o;
  wire  [17:0] tr_o;
  logic [15:0] cen [4] = '{16'hFFFF, 16'hFFFF, 16'h0106, 16'hFFFD};
  logic [16:0] crp [4] = '{17'h0_C001, 17'h0_8002, 17'h1_4003, 17'h1_4005};
  int          failures = 0, total_checks = 0, cyc = 0;

  pcb_host pcb_host_i (.clk, .wr_stb, .wr_addr, .wr_data);
  pcb_bank pcb_bank_i (.clk, .rst, .wr_stb, .wr_addr, .wr_data, .rd_addr,
    .rd_data, .loop_enable, .vco_buf_enable(en_o[0]),
    .ref_div_run(en_o[1]), .ref_div_use, .ref_div_ratio,
    .xmux_clk_gate(en_o[2]), .div_clk_gate(en_o[3]), .sq_clk_gate(en_o[4]),
    .sin_clk_gate(en_o[5]), .square_ref_buffer_enable(sq_buf),
    .sine_ref_buffer_enable(sin_buf), .mod_clk_from_vco,
    .presc_bias_enable(en_o[6]), .lock_det_run(en_o[7]),
    .pump_output_enable, .mod_run, .lock_circ_run(en_o[8]),
    .cycle_slip_guard(en_o[9]), .lock_or_readback_pin_o(pin_o),
    .lock_or_readback_pin_oe(pin_oe), .presc_long_low(pd_o[0]),
    .pd_invert(pd_o[1]), .pd_up_pass(pd_o[2]), .pd_down_pass(pd_o[3]),
    .pd_delay(pd_o[6:4]), .pump_up_gain_code(pd_o[11:7]),
    .pump_down_gain_code(pd_o[16:12]), .pump_up_trim_code(tr_o[3:0]),
    .pump_down_trim_code(tr_o[7:4]), .pump_up_leak_code(tr_o[11:8]),
    .pump_down_leak_code(tr_o[15:12]), .pump_dummy_bias_code(tr_o[17:16]));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      complete_run();
    end
  end

  function automatic logic [23:0] dflt(input logic [5:0] x, input bit m);
    case (x)
      6'h01: dflt = m ? 24'h00_FFFF : 24'h00_FE9B;
      6'h02: dflt = 24'h00_0003;
      6'h03: dflt = m ? 24'h01_FFFF : 24'h00_8001;
      6'h04: dflt = m ? 24'h00_0001 : 24'h00_0000;
      6'h05: dflt = m ? 24'h00_0007 : 24'h00_0006;
      6'h06: dflt = m ? 24'h00_0007 : 24'h00_0002;
      6'h07: dflt = m ? 24'h00_03FF : 24'h00_0210;
      6'h08: dflt = m ? 24'h03_FFFF : 24'h02_0400;
      default: dflt = 24'h00_0000;
    endcase
  endfunction

  function automatic logic div_use(input logic [15:0] e, input logic [16:0] r);
    div_use = e[2] & (r[15] ? r[13:0] != 14'h0001 : r[14]);
  endfunction

  function automatic logic [9:0] en_exp(input logic [15:0] e);
    en_exp = {e[15:14], e[11:10], e[6:2], e[0]} & {10{e[1]}};
  endfunction

  task automatic chk(input string n, input logic [23:0] s, e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic set_dflt;
    en_s = 16'hFE9B;
    fr_s = 2'h3;
    rp_s = 17'h0_8001;
    for (int i = 0; i < 9; i++) sh[i] = dflt(6'(i), 0);
  endtask

  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    set_dflt();
  endtask

  task automatic wr(input logic [5:0] x, input logic [23:0] y);
    pcb_host_i.write(x, y);
    if (x == 6'h01) en_s = y[15:0];
    if (x == 6'h02) fr_s = y[1:0];
    if (x == 6'h03) rp_s = y[16:0];
    if (x > 6'h00 && x < 6'h09) sh[x] = y & dflt(x, 1);
    if (x == 6'h00 && y[0]) set_dflt();
  endtask

  task automatic rd(input logic [5:0] x, input logic [23:0] e);
    @(posedge clk);
    rd_addr <= x;
    repeat (2) @(posedge clk);
    #1;
    chk("rd_data", rd_data, e);
  endtask

  task automatic chk_der;
    chk("loop_enable", loop_enable, en_s[1]);
    chk("pump_output_enable", pump_output_enable, en_s[1] & en_s[12]);
    chk("mod_run", mod_run, en_s[1] & en_s[13]);
    chk("mod_clk_from_vco", mod_clk_from_vco, en_s[9]);
    chk("ref_div_use", ref_div_use, div_use(en_s, rp_s));
    chk("ref_div_ratio", ref_div_ratio, rp_s[13:0]);
    chk("sq_buf", sq_buf, en_s[1] & en_s[7] & ~rp_s[16]);
    chk("sin_buf", sin_buf, en_s[1] & en_s[8] & rp_s[16]);
    chk("pin", {pin_oe, pin_o}, fr_s);
    chk("en_o", en_o, en_exp(en_s));
    chk("pd_o", pd_o[6:0], {sh[6][2:0], sh[5][2:0], sh[4][0]});
    chk("gain", pd_o[16:7], sh[7][9:0]);
    chk("tr_o", tr_o, sh[8][17:0]);
  endtask

  initial begin
    rst = 1'b1;
    rd_addr = 6'h00;
    d = $urandom(82261);
    do_reset();
    for (int i = 0; i < 10; i++) rd(6'(i), dflt(6'(i), 0));
    chk_der();
    $display("test defaults done");
    repeat (30) begin
      a = 6'($urandom_range(1, 9));
      d = $urandom;
      if (a == 6'h03 && d[13:0] == 14'h0000) d[0] = 1'b1;
      if (a == 6'h06) d[2:0] = 3'b001;
      if (a == 6'h08) d[17:16] = 2'b10;
      wr(a, d);
      rd(a, d & dflt(a, 1));
      chk_der();
    end
    $display("test random done");
    foreach (cen[i]) begin
      wr(6'h01, {8'h00, cen[i]});
      wr(6'h03, {7'h00, crp[i]});
      rd(6'h01, {8'h00, cen[i]});
      chk_der();
    end
    $display("test corners done");
    wr(6'h00, 24'h00_0002);
    rd(6'h03, {7'h00, rp_s});
    wr(6'h00, 24'h00_0001);
    for (int i = 1; i < 9; i++) rd(6'(i), dflt(6'(i), 0));
    chk_der();
    $display("test soft reset done");
    wr(6'h07, 24'hFF_FFFF);
    do_reset();
    rd(6'h07, 24'h00_0210);
    $display("test mid reset done");
    complete_run();
  end
endmodule
`default_nettype wire
